// >>> common/velocity_pid_pkg.sv
// Package for the velocity PID loop controller.
// Assumes a 20 MHz system clock and signed 16-bit fixed-point signals.
package velocity_pid_pkg;

	// ----------------------------------------------------------------
	// Data widths and fixed-point format
	// ----------------------------------------------------------------
	localparam int DATA_W  = 16;
	localparam int GAIN_W  = 16;
	localparam int GAIN_FRAC = 8;
	localparam int ACC_W   = 32;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ        = 20000000;
	localparam int UPDATE_HZ     = 1000;
	localparam int TICK_CYCLES   = CLK_HZ / UPDATE_HZ;
	localparam int TICK_CNT_W    = 15;

	// ----------------------------------------------------------------
	// Loop mode encodings, output limits and reset value
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_OPEN   = 2'h0;
	localparam logic [1:0] MODE_CLOSED = 2'h2;
	localparam logic signed [DATA_W-1:0] OUT_MAX = 16'h7FFF;
	localparam logic signed [DATA_W-1:0] OUT_MIN = 16'h8001;
	localparam logic signed [ACC_W-1:0]  ACC_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Grouped tuning coefficients
	// ----------------------------------------------------------------
	typedef struct packed {
		logic signed [GAIN_W-1:0] proportional_gain;
		logic signed [GAIN_W-1:0] integral_gain;
		logic signed [GAIN_W-1:0] derivative_gain;
		logic signed [GAIN_W-1:0] feedforward_gain;
		logic        [DATA_W-1:0] integrator_window;
		logic        [DATA_W-1:0] deadband_offset_side_a;
		logic        [DATA_W-1:0] deadband_offset_side_b;
		logic [1:0]               loop_mode_select;
		logic                     command_polarity;
		logic                     feedback_polarity;
	} pid_config_t;

endpackage

// >>> verilog/update_tick.sv
// Periodic update tick generator for the control loop.
// Assumes a free-running clock at the package clock rate.
`timescale 1ns/1ps
module update_tick
	import velocity_pid_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// Tick
	output logic      tick_o
);

	typedef struct packed {
		logic [TICK_CNT_W-1:0] count;
		logic                  tick;
	} tick_state_t;

	tick_state_t state;
	tick_state_t next_state;

	// Count clock cycles and pulse once every update period.
	always_comb
	begin
		next_state = state;
		next_state.tick = 1'b0;
		if (state.count == TICK_CNT_W'(TICK_CYCLES - 1))
		begin
			next_state.count = '0;
			next_state.tick = 1'b1;
		end
		else
			next_state.count = state.count + 1'b1;
	end

	// State register.
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			state <= '0;
		else
			state <= next_state;
	end

	assign tick_o = state.tick;

endmodule

// >>> verilog/velocity_pid_loop_controller.sv
// Velocity PID loop controller with feedforward and dead band offsets.
// Assumes coefficient inputs are quasi-static and position samples come
// from an asynchronous converter, so they are synchronised here.
`timescale 1ns/1ps
module velocity_pid_loop_controller
	import velocity_pid_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     reset_n_i,
	// Configuration
	input  wire pid_config_t              config_i,
	// Command and transducer
	input  wire logic signed [DATA_W-1:0] velocity_command_i,
	input  wire logic signed [DATA_W-1:0] position_sample_i,
	// Valve output
	output logic signed [DATA_W-1:0]      valve_output_o,
	output logic                          output_update_o,
	// Status
	output logic signed [DATA_W-1:0]      measured_velocity_o,
	output logic                          integrator_active_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Saturate a wide signed value into the output range.
	function automatic logic signed [DATA_W-1:0] sat16(
		input logic signed [ACC_W-1:0] v);
		if (v > ACC_W'(OUT_MAX))
			sat16 = OUT_MAX;
		else if (v < ACC_W'(OUT_MIN))
			sat16 = OUT_MIN;
		else
			sat16 = v[DATA_W-1:0];
	endfunction

	// Gain times signal, rescaled by the fractional bits.
	function automatic logic signed [ACC_W-1:0] scale(
		input logic signed [GAIN_W-1:0] g,
		input logic signed [DATA_W-1:0] x);
		logic signed [ACC_W-1:0] p;
		p = g * x;
		scale = p >>> GAIN_FRAC;
	endfunction

	// Optional sign inversion.
	function automatic logic signed [DATA_W-1:0] polar(
		input logic signed [DATA_W-1:0] x,
		input logic                     inv);
		polar = inv ? sat16(-ACC_W'(x)) : x;
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisers and tick
	// ----------------------------------------------------------------
	typedef struct packed {
		logic signed [DATA_W-1:0] cmd_s1;
		logic signed [DATA_W-1:0] cmd_s2;
		logic signed [DATA_W-1:0] cmd_s3;
		logic signed [DATA_W-1:0] cmd_hold;
		logic signed [DATA_W-1:0] pos_s1;
		logic signed [DATA_W-1:0] pos_s2;
		logic signed [DATA_W-1:0] pos_s3;
		logic signed [DATA_W-1:0] pos_hold;
		logic signed [DATA_W-1:0] pos_prev;
		logic signed [DATA_W-1:0] vel;
		logic signed [DATA_W-1:0] vel_prev;
		logic signed [ACC_W-1:0]  integ;
		logic signed [DATA_W-1:0] out;
		logic                     update;
		logic                     int_active;
		logic                     primed;
	} ctrl_state_t;

	ctrl_state_t state;
	ctrl_state_t next_state;
	logic        tick;

	update_tick u_tick (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.tick_o    (tick)
	);

	// ----------------------------------------------------------------
	// Control law
	// ----------------------------------------------------------------
	logic signed [DATA_W-1:0] cmd;
	logic signed [DATA_W-1:0] fb;
	logic signed [DATA_W-1:0] vel_now;
	logic signed [DATA_W-1:0] err;
	logic signed [DATA_W-1:0] dvel;
	logic signed [ACC_W-1:0]  p_term;
	logic signed [ACC_W-1:0]  d_term;
	logic signed [ACC_W-1:0]  ff_term;
	logic signed [ACC_W-1:0]  db_term;
	logic signed [ACC_W-1:0]  integ_next;
	logic signed [ACC_W-1:0]  sum;
	logic                     closed;
	logic                     win_on;

	// Compute each term from the held samples, with the velocities registered at earlier ticks as feedback;
	// apart from the input synchronisers and holds, the state moves only on the tick, so the law runs once per update period.
	always_comb
	begin
		closed  = (config_i.loop_mode_select == MODE_CLOSED);
		win_on  = (config_i.integrator_window != '0);
		cmd     = polar(state.cmd_hold, config_i.command_polarity);
		vel_now = sat16(ACC_W'(state.pos_hold) -
			ACC_W'(state.pos_prev));
		fb      = polar(state.vel, config_i.feedback_polarity);
		err     = sat16(ACC_W'(cmd) - ACC_W'(fb));
		dvel    = sat16(ACC_W'(fb) - ACC_W'(polar(state.vel_prev,
			config_i.feedback_polarity)));
		p_term  = scale(config_i.proportional_gain, err);
		d_term  = scale(config_i.derivative_gain, dvel);
		ff_term = scale(config_i.feedforward_gain, cmd);
		// Dead band offset follows the sign of the command.
		if (cmd > 0)
			db_term = ACC_W'(config_i.deadband_offset_side_a);
		else if (cmd < 0)
			db_term = -ACC_W'(config_i.deadband_offset_side_b);
		else
			db_term = '0;
		// Integrator runs only in closed loop with a window defined.
		// The accumulator is clamped so it cannot wind up unboundedly.
		if (closed && win_on)
			integ_next = ACC_W'(sat16(state.integ +
				scale(config_i.integral_gain, err)));
		else
			integ_next = '0;
		if (closed)
			sum = p_term + integ_next + d_term;
		else
			sum = '0;
		sum = sum + ff_term + db_term;

		next_state        = state;
		next_state.cmd_s1 = velocity_command_i;
		next_state.cmd_s2 = state.cmd_s1;
		next_state.pos_s1 = position_sample_i;
		next_state.pos_s2 = state.pos_s1;
		next_state.cmd_s3 = state.cmd_s2;
		next_state.pos_s3 = state.pos_s2;
		// A word is taken only once two synchronised samples agree, so a
		// word torn across its bits by the crossing never reaches the law.
		// A word that changes on every clock is therefore never taken.
		if (state.cmd_s2 == state.cmd_s3)
			next_state.cmd_hold = state.cmd_s3;
		if (state.pos_s2 == state.pos_s3)
			next_state.pos_hold = state.pos_s3;
		next_state.update = 1'b0;
		if (tick)
		begin
			next_state.pos_prev   = state.pos_hold;
			next_state.primed     = 1'b1;
			// First sample has no predecessor, so velocity stays zero.
			next_state.vel        = state.primed ? vel_now : '0;
			next_state.vel_prev   = state.vel;
			next_state.integ      = integ_next;
			next_state.int_active = closed && win_on;
			next_state.out        = sat16(sum);
			next_state.update     = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state       <= '0;
			state.integ <= ACC_RESET;
		end
		else
			state <= next_state;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign valve_output_o      = state.out;
	assign output_update_o     = state.update;
	assign measured_velocity_o = state.vel;
	assign integrator_active_o = state.int_active;

endmodule

// >>> verification/velocity_pid_props.sv
// Port checker for the velocity PID loop controller.
// Assumes a bind to the top module; one clock domain.
`timescale 1ns/1ps
module velocity_pid_props
	import velocity_pid_pkg::*;
(
	// Clock and reset
	input wire logic			clk_i,
	input wire logic			reset_n_i,
	// Watched ports
	input wire pid_config_t			config_i,
	input wire logic signed [DATA_W-1:0]	valve_output_o,
	input wire logic			output_update_o,
	input wire logic signed [DATA_W-1:0]	measured_velocity_o,
	input wire logic			integrator_active_o
);
	logic [TICK_CNT_W-1:0]	gap;
	logic			seen;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// Cycles since the last update pulse; the first gap is not judged.
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			gap <= '0;
			seen <= 1'b0;
		end
		else if (output_update_o)
		begin
			gap <= '0;
			seen <= 1'b1;
		end
		else
			gap <= gap + 1'b1;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	pulse_single_a: assert property (output_update_o |=> !output_update_o)
		else $error("update pulse longer than one cycle");
	pulse_gap_a: assert property (output_update_o && seen |->
		gap == TICK_CYCLES - 1) else $error("update spacing wrong");
	tick_late_a: assert property (seen |-> gap < TICK_CYCLES)
		else $error("update pulse missing");
	out_hold_a: assert property (!output_update_o |->
		$stable(valve_output_o)) else $error("output moved off tick");
	vel_hold_a: assert property (!output_update_o |->
		$stable(measured_velocity_o)) else $error("velocity moved off tick");
	integ_gate_a: assert property (output_update_o |-> integrator_active_o ==
		($past(config_i.loop_mode_select) == MODE_CLOSED &&
		$past(config_i.integrator_window) != '0)) else $error("integrator gate");
	out_sat_a: assert property (valve_output_o != 16'h8000)
		else $error("output below saturation floor");
	open_zero_a: assert property (output_update_o &&
		$past(config_i.loop_mode_select) != MODE_CLOSED &&
		$past(config_i.feedforward_gain) == '0 &&
		$past(config_i.deadband_offset_side_a) == '0 &&
		$past(config_i.deadband_offset_side_b) == '0 |->
		valve_output_o == '0) else $error("open loop output not zero");
endmodule

// >>> verification/position_transducer_model.sv
// Behavioural position transducer on the far side of the valve.
// Assumes the drive moves step_i counts per valve update.
`timescale 1ns/1ps
module position_transducer_model
	import velocity_pid_pkg::*;
(
	// Clock and reset
	input wire logic			clk_i,
	input wire logic			reset_n_i,
	// Drive motion
	input wire logic			advance_i,
	input wire logic signed [DATA_W-1:0]	step_i,
	output logic signed [DATA_W-1:0]	position_o
);
	// One step per update keeps every tick's position delta equal.
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			position_o <= '0;
		else if (advance_i)
			position_o <= position_o + step_i;
	end
endmodule

// >>> verification/velocity_pid_loop_controller_bench.sv
// Self-checking bench: four update ticks, one scenario per tick.
// Assumes the fixed 20000-cycle tick; the drive moves 10 per tick.
`timescale 1ns/1ps
module velocity_pid_loop_controller_bench
	import velocity_pid_pkg::*;
;
	logic			clk_i;
	logic			reset_n_i;
	pid_config_t		cfg;
	logic signed [15:0]	cmd;
	logic signed [15:0]	pos;
	logic signed [15:0]	out;
	logic signed [15:0]	mvel;
	logic			upd;
	logic			iact;
	int			fails;
	int			checked;
	int			cycles;

	velocity_pid_loop_controller dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.config_i(cfg), .velocity_command_i(cmd), .position_sample_i(pos),
		.valve_output_o(out), .output_update_o(upd),
		.measured_velocity_o(mvel), .integrator_active_o(iact));
	position_transducer_model drive (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.advance_i(upd), .step_i(16'h000A), .position_o(pos));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Waits for the next update pulse; inputs change 5 ns after edges.
	task automatic wait_tick();
		int n;
		n = 0;
		do
		begin
			@(posedge clk_i);
			#5;
			n++;
		end
		while (upd !== 1'b1 && n < 20010);
		if (upd !== 1'b1)
		begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, upd, 1'b1);
		end
	endtask

	task automatic end_sim();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Open loop with no bypass or offsets: the proportional gain must
	// not leak into the output, so it stays at zero.
	task automatic t_open();
		cfg = '0;
		cfg.proportional_gain = 16'h0200;
		cmd = 16'h0064;
		wait_tick();
		chk(out, 16'h0000);
		$display("open loop test done");
	endtask

	// Open loop, negative command: bypass plus the side B offset.
	task automatic t_side_b();
		cfg.feedforward_gain = 16'h0100;
		cfg.deadband_offset_side_a = 16'h0005;
		cfg.deadband_offset_side_b = 16'h0007;
		cmd = 16'hFF9C;
		wait_tick();
		chk(out, 16'hFF95);
		chk(mvel, 16'h000A);
		$display("side b test done");
	endtask

	// Closed loop with the previous tick's velocity as feedback.
	task automatic t_closed();
		cfg = '0;
		cfg.loop_mode_select = MODE_CLOSED;
		cfg.proportional_gain = 16'h0200;
		cfg.derivative_gain = 16'hFF00;
		cfg.deadband_offset_side_a = 16'h0005;
		cmd = 16'h0064;
		wait_tick();
		chk(out, 16'h00AF);
		chk({15'h0000, iact}, 16'h0000);
		$display("closed loop test done");
	endtask

	// Both polarities inverted, integrator opened by a nonzero window.
	task automatic t_invert();
		cfg.command_polarity = 1'b1;
		cfg.feedback_polarity = 1'b1;
		cfg.integral_gain = 16'h0100;
		cfg.integrator_window = 16'h0001;
		wait_tick();
		chk(out, 16'hFEF2);
		chk({15'h0000, iact}, 16'h0001);
		$display("inversion test done");
	endtask

	// Free-running clock at 20 MHz.
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// A hang ends the run after the four ticks should have passed.
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, cycles, 0);
			end_sim();
		end
	end

	// Main sequence: reset for six cycles, then the scenarios.
	initial
	begin
		fails = 0;
		checked = 0;
		cycles = 0;
		reset_n_i = 1'b0;
		cfg = '0;
		cmd = '0;
		repeat (6) @(posedge clk_i);
		#5 reset_n_i = 1'b1;
		t_open();
		t_side_b();
		t_closed();
		t_invert();
		end_sim();
	end
endmodule

bind velocity_pid_loop_controller velocity_pid_props props (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .config_i(config_i),
	.valve_output_o(valve_output_o), .output_update_o(output_update_o),
	.measured_velocity_o(measured_velocity_o),
	.integrator_active_o(integrator_active_o));
